// file: rtl/jdp_cfg.svh
// Constants for the test-access and debug-entry port
// Contract
// - Sample serial data in on test clock rise
// - Sample mode select on rise, step controller
// - Drive data out only in shift states
// - Data out changes on falling edges only
// - Test reset clears controller asynchronously
// - Debug line is open-drain, active-low, two-way
// - Request: finish instruction, save, enter debug
// - Acknowledge debug entry with three-cycle low
// - Other debug traffic uses serial port only
`ifndef JDP_CFG_SVH
`define JDP_CFG_SVH
`define JDP_IR_W 4
`define JDP_DR_W 32
`define JDP_IR_RESET 4'h1
`define JDP_IR_CAPTURE 4'h1
`define JDP_IR_BYPASS 4'hf
`define JDP_IR_DEBUG 4'h7
`define JDP_IR_IDCODE 4'h2
`define JDP_ID_VALUE 32'h00000001
`define JDP_ACK_CYCLES 2'h3
`endif

// file: rtl/jdp_pkg.sv
// Types for the test-access and debug-entry port
package jdp_pkg;
    typedef enum logic [3:0] {
        JDP_RESET, JDP_IDLE, JDP_SEL_DR, JDP_CAP_DR, JDP_SH_DR, JDP_EX1_DR,
        JDP_PAU_DR, JDP_EX2_DR, JDP_UPD_DR, JDP_SEL_IR, JDP_CAP_IR, JDP_SH_IR,
        JDP_EX1_IR, JDP_PAU_IR, JDP_EX2_IR, JDP_UPD_IR
    } jdp_tap_t;
    typedef struct packed {
        logic tdi;
        logic tms;
    } jdp_serial_in_t;
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } jdp_serial_out_t;
    typedef enum logic [1:0] {
        JDP_RUN, JDP_DRAIN, JDP_DEBUG
    } jdp_core_t;
endpackage

// file: rtl/jdp_port.sv
// Test-access port and debug-event line for the core
`timescale 1ns/1ps
`include "jdp_cfg.svh"
module jdp_port (
    // Core clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Test port
    input wire logic tck_i,
    input wire logic test_nrst_i,
    input wire jdp_pkg::jdp_serial_in_t ser_i,
    output jdp_pkg::jdp_serial_out_t ser_o,
    // Debug-event pin, open drain
    input wire logic debug_event_pin_i,
    output logic debug_event_pin_o,
    output logic debug_event_pin_oe_o,
    // Core side
    input wire logic instr_done_i,
    input wire logic breakpoint_i,
    output logic save_pipe_o,
    output logic debug_mode_o,
    output logic [`JDP_DR_W-1:0] cmd_data_o,
    output logic cmd_valid_o
);
    import jdp_pkg::*;

    // =========================================================
    // Core reset release
    logic rst_s1, rst_s2;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_s1 <= 1'b0;
            rst_s2 <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_s2 <= rst_s1;
        end
    end

    // =========================================================
    // Test controller state
    jdp_tap_t tap, next_tap;
    always_comb begin
        next_tap = tap;
        unique case (tap)
            JDP_RESET: next_tap = ser_i.tms ? JDP_RESET : JDP_IDLE;
            JDP_IDLE: next_tap = ser_i.tms ? JDP_SEL_DR : JDP_IDLE;
            JDP_SEL_DR: next_tap = ser_i.tms ? JDP_SEL_IR : JDP_CAP_DR;
            JDP_CAP_DR: next_tap = ser_i.tms ? JDP_EX1_DR : JDP_SH_DR;
            JDP_SH_DR: next_tap = ser_i.tms ? JDP_EX1_DR : JDP_SH_DR;
            JDP_EX1_DR: next_tap = ser_i.tms ? JDP_UPD_DR : JDP_PAU_DR;
            JDP_PAU_DR: next_tap = ser_i.tms ? JDP_EX2_DR : JDP_PAU_DR;
            JDP_EX2_DR: next_tap = ser_i.tms ? JDP_UPD_DR : JDP_SH_DR;
            JDP_UPD_DR: next_tap = ser_i.tms ? JDP_SEL_DR : JDP_IDLE;
            JDP_SEL_IR: next_tap = ser_i.tms ? JDP_RESET : JDP_CAP_IR;
            JDP_CAP_IR: next_tap = ser_i.tms ? JDP_EX1_IR : JDP_SH_IR;
            JDP_SH_IR: next_tap = ser_i.tms ? JDP_EX1_IR : JDP_SH_IR;
            JDP_EX1_IR: next_tap = ser_i.tms ? JDP_UPD_IR : JDP_PAU_IR;
            JDP_PAU_IR: next_tap = ser_i.tms ? JDP_EX2_IR : JDP_PAU_IR;
            JDP_EX2_IR: next_tap = ser_i.tms ? JDP_UPD_IR : JDP_SH_IR;
            JDP_UPD_IR: next_tap = ser_i.tms ? JDP_SEL_DR : JDP_IDLE;
        endcase
    end

    // =========================================================
    // Instruction and data shifting
    logic [`JDP_IR_W-1:0] ir_sh, next_ir_sh, ir, next_ir;
    logic [`JDP_DR_W-1:0] dr_sh, next_dr_sh, cmd, next_cmd;
    logic cmd_tgl, next_cmd_tgl;
    always_comb begin
        next_ir_sh = ir_sh;
        next_ir = ir;
        next_dr_sh = dr_sh;
        next_cmd = cmd;
        next_cmd_tgl = cmd_tgl;
        unique case (tap)
            JDP_CAP_IR: next_ir_sh = `JDP_IR_CAPTURE;
            JDP_SH_IR: next_ir_sh = {ser_i.tdi, ir_sh[`JDP_IR_W-1:1]};
            JDP_UPD_IR: next_ir = ir_sh;
            JDP_CAP_DR: begin
                if (ir == `JDP_IR_IDCODE) begin
                    next_dr_sh = `JDP_ID_VALUE;
                end else begin
                    next_dr_sh = '0;
                end
            end
            JDP_SH_DR: begin
                if (ir == `JDP_IR_BYPASS) begin
                    next_dr_sh = {{(`JDP_DR_W-1){1'b0}}, ser_i.tdi};
                end else begin
                    next_dr_sh = {ser_i.tdi, dr_sh[`JDP_DR_W-1:1]};
                end
            end
            JDP_UPD_DR: begin
                if (ir == `JDP_IR_DEBUG) begin
                    next_cmd = dr_sh;
                    next_cmd_tgl = ~cmd_tgl;
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge tck_i or negedge test_nrst_i) begin
        if (!test_nrst_i) begin
            tap <= JDP_RESET;
            ir_sh <= '0;
            ir <= `JDP_IR_RESET;
            dr_sh <= '0;
            cmd <= '0;
            cmd_tgl <= 1'b0;
        end else begin
            tap <= next_tap;
            ir_sh <= next_ir_sh;
            ir <= (tap == JDP_RESET) ? `JDP_IR_RESET : next_ir;
            dr_sh <= next_dr_sh;
            cmd <= next_cmd;
            cmd_tgl <= next_cmd_tgl;
        end
    end

    // =========================================================
    // Serial output on falling edge
    jdp_serial_out_t next_so;
    always_comb begin
        next_so.tdo = 1'b0;
        next_so.tdo_oe = 1'b0;
        if (tap == JDP_SH_IR) begin
            next_so.tdo = ir_sh[0];
            next_so.tdo_oe = 1'b1;
        end else if (tap == JDP_SH_DR) begin
            next_so.tdo = dr_sh[0];
            next_so.tdo_oe = 1'b1;
        end
    end

    always_ff @(negedge tck_i or negedge test_nrst_i) begin
        if (!test_nrst_i) begin
            ser_o <= '0;
        end else begin
            ser_o <= next_so;
        end
    end

    // =========================================================
    // Core-domain crossing of commands and debug pin
    logic tg_s1, tg_s2, tg_s3, de_s1, de_s2;
    always_ff @(posedge clk_i or negedge rst_s2) begin
        if (!rst_s2) begin
            tg_s1 <= 1'b0;
            tg_s2 <= 1'b0;
            tg_s3 <= 1'b0;
            de_s1 <= 1'b1;
            de_s2 <= 1'b1;
        end else begin
            tg_s1 <= cmd_tgl;
            tg_s2 <= tg_s1;
            tg_s3 <= tg_s2;
            de_s1 <= debug_event_pin_i;
            de_s2 <= de_s1;
        end
    end

    // =========================================================
    // Debug entry and acknowledge
    jdp_core_t cst, next_cst;
    logic [1:0] ack, next_ack;
    logic next_save, next_dbg, next_dov, next_doe, next_cv;
    logic [`JDP_DR_W-1:0] next_cd;
    logic enter;
    always_comb begin
        next_cst = cst;
        next_ack = ack;
        next_save = 1'b0;
        next_dbg = debug_mode_o;
        next_cv = 1'b0;
        next_cd = cmd_data_o;
        enter = 1'b0;
        unique case (cst)
            JDP_RUN: begin
                if (breakpoint_i) begin
                    enter = 1'b1;
                end else if (!de_s2) begin
                    next_cst = JDP_DRAIN;
                end
            end
            JDP_DRAIN: begin
                if (instr_done_i) begin
                    enter = 1'b1;
                end
            end
            JDP_DEBUG: begin
                if (tg_s2 != tg_s3) begin
                    next_cd = cmd;
                    next_cv = 1'b1;
                end
            end
            default: next_cst = JDP_RUN;
        endcase
        if (enter) begin
            next_cst = JDP_DEBUG;
            next_save = 1'b1;
            next_dbg = 1'b1;
            next_ack = `JDP_ACK_CYCLES;
        end else if (ack != 2'h0) begin
            next_ack = ack - 2'h1;
        end
        next_doe = (next_ack != 2'h0);
        next_dov = 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_s2) begin
        if (!rst_s2) begin
            cst <= JDP_RUN;
            ack <= 2'h0;
            save_pipe_o <= 1'b0;
            debug_mode_o <= 1'b0;
            cmd_data_o <= '0;
            cmd_valid_o <= 1'b0;
            debug_event_pin_o <= 1'b0;
            debug_event_pin_oe_o <= 1'b0;
        end else begin
            cst <= next_cst;
            ack <= next_ack;
            save_pipe_o <= next_save;
            debug_mode_o <= next_dbg;
            cmd_data_o <= next_cd;
            cmd_valid_o <= next_cv;
            debug_event_pin_o <= next_dov;
            debug_event_pin_oe_o <= next_doe;
        end
    end

    // =========================================================
    // Checks
    sequence s_enter;
        save_pipe_o;
    endsequence
    sequence s_ack_hold;
        debug_event_pin_oe_o [*3] ##1 !debug_event_pin_oe_o;
    endsequence
    sequence s_cmd_seen;
        cst == JDP_DEBUG && tg_s2 != tg_s3;
    endsequence
    a_ack_three: assert property (@(posedge clk_i) disable iff (!rst_s2)
        s_enter |-> s_ack_hold)
        else $error("acknowledge not three cycles");
    a_ack_cause: assert property (@(posedge clk_i) disable iff (!rst_s2)
        $rose(debug_event_pin_oe_o) |-> save_pipe_o)
        else $error("acknowledge without entry");
    a_drive_low: assert property (@(posedge clk_i) disable iff (!rst_s2)
        debug_event_pin_oe_o |-> !debug_event_pin_o)
        else $error("debug line driven high");
    a_drain_wait: assert property (@(posedge clk_i) disable iff (!rst_s2)
        (cst == JDP_DRAIN && !instr_done_i) |=> !save_pipe_o)
        else $error("entry before instruction done");
    a_req_enter: assert property (@(posedge clk_i) disable iff (!rst_s2)
        (cst == JDP_RUN && !de_s2 && !breakpoint_i) |=> cst == JDP_DRAIN)
        else $error("request not taken");
    a_tdo_shift: assert property (@(negedge tck_i) disable iff (!test_nrst_i)
        ##1 ser_o.tdo_oe |-> ($past(tap) == JDP_SH_IR || $past(tap) == JDP_SH_DR))
        else $error("data out driven outside shift");
    a_tap_reset: assert property (@(posedge tck_i) disable iff (!test_nrst_i)
        (ser_i.tms [*5]) |=> tap == JDP_RESET)
        else $error("five mode ones do not reset");
    a_ir_update: assert property (@(posedge tck_i) disable iff (!test_nrst_i)
        (tap == JDP_UPD_IR && !ser_i.tms) |=> (ir == $past(ir_sh) && tap == JDP_IDLE))
        else $error("instruction update failed");
    a_cap_ir: assert property (@(posedge tck_i) disable iff (!test_nrst_i)
        (tap == JDP_CAP_IR) |=> ir_sh == `JDP_IR_CAPTURE)
        else $error("instruction capture value wrong");
    a_bypass_bit: assert property (@(posedge tck_i) disable iff (!test_nrst_i)
        (tap == JDP_SH_DR && ir == `JDP_IR_BYPASS) |=> dr_sh[0] == $past(ser_i.tdi))
        else $error("bypass bit not taken");
    a_dr_shift: assert property (@(posedge tck_i) disable iff (!test_nrst_i)
        (tap == JDP_SH_DR && ir != `JDP_IR_BYPASS) |=> dr_sh[`JDP_DR_W-1] == $past(ser_i.tdi))
        else $error("data bit not taken");
    a_tap_idle: assert property (@(posedge tck_i) disable iff (!test_nrst_i)
        (tap == JDP_IDLE) |=> tap == ($past(ser_i.tms) ? JDP_SEL_DR : JDP_IDLE))
        else $error("idle move wrong");

    // =========================================================
    // Core-side checks
    a_brk_enter: assert property (@(posedge clk_i) disable iff (!rst_s2)
        (cst == JDP_RUN && breakpoint_i) |=> (save_pipe_o && debug_mode_o))
        else $error("breakpoint entry missing");
    a_mode_hold: assert property (@(posedge clk_i) disable iff (!rst_s2)
        debug_mode_o |=> debug_mode_o)
        else $error("debug mode dropped");
    a_no_reenter: assert property (@(posedge clk_i) disable iff (!rst_s2)
        (cst == JDP_DEBUG) |=> !save_pipe_o)
        else $error("entry repeated in debug");
    a_save_pulse: assert property (@(posedge clk_i) disable iff (!rst_s2)
        save_pipe_o |=> !save_pipe_o)
        else $error("save pulse too long");
    a_pin_release: assert property (@(posedge clk_i) disable iff (!rst_s2)
        (ack == 2'h1) |=> !debug_event_pin_oe_o)
        else $error("debug line not released");
    a_cmd_deliver: assert property (@(posedge clk_i) disable iff (!rst_s2)
        s_cmd_seen |=> (cmd_valid_o && cmd_data_o == $past(cmd)))
        else $error("command not delivered");
    a_cmd_gated: assert property (@(posedge clk_i) disable iff (!rst_s2)
        (cst != JDP_DEBUG) |=> !cmd_valid_o)
        else $error("command outside debug mode");
endmodule

// file: dv/jdp_ctl_model.sv
// Model of the external test and debug command controller
`timescale 1ns/1ps
module jdp_ctl_model (
    // Test port
    output logic tck_o,
    output logic test_nrst_o,
    output jdp_pkg::jdp_serial_in_t ser_o,
    input wire logic tdo_i,
    // Debug-event pull
    output logic pull_o
);
    import jdp_pkg::*;
    initial begin
        tck_o = 1'b0;
        test_nrst_o = 1'b0;
        ser_o = '1;
        pull_o = 1'b0;
    end
    // ====================
    // Frame steps, clock idle low
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        ser_o.tms = tms;
        ser_o.tdi = tdi;
        #15;
        tdo = tdo_i;
        tck_o = 1'b1;
        #15;
        tck_o = 1'b0;
    endtask
    task automatic treset();
        test_nrst_o = 1'b0;
        #10;
        test_nrst_o = 1'b1;
        #5;
    endtask
    task automatic pull(input logic v);
        pull_o <= v;
    endtask
    task automatic shift(input bit ir, input int n, input logic [31:0] v, output logic [31:0] q);
        logic b;
        q = '0;
        step(1'b1, 1'b0, b);
        if (ir) step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
        step(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, v[i], b);
            q[i] = b;
        end
        step(1'b1, 1'b0, b);
        step(1'b0, 1'b0, b);
    endtask
endmodule

// file: dv/jtag_debug_entry_port_test.sv
// Testbench for the test-access and debug-entry port
`timescale 1ns/1ps
`include "jdp_cfg.svh"
module jtag_debug_entry_port_test;
    import jdp_pkg::*;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic instr_done = 1'b0;
    logic brk = 1'b0;
    logic tck, test_nrst, pull, dbg_o, dbg_oe, save, dbg_mode, cmd_valid;
    jdp_serial_in_t ser_in;
    jdp_serial_out_t ser_out;
    logic [31:0] cmd_data, q, v;
    logic [31:0] cmd_q[$];
    wire tdo_w = ser_out.tdo_oe ? ser_out.tdo : 1'bz;
    wire pin_w = (pull || (dbg_oe && !dbg_o)) ? 1'b0 : 1'b1;
    int n_mismatch = 0;
    int check_count = 0;
    int oe_cnt = 0;
    int save_cnt = 0;
    always #20 clk_i = ~clk_i;
    jdp_ctl_model ctl_u (.tck_o(tck), .test_nrst_o(test_nrst), .ser_o(ser_in),
        .tdo_i(tdo_w), .pull_o(pull));
    jdp_port dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .tck_i(tck), .test_nrst_i(test_nrst),
        .ser_i(ser_in), .ser_o(ser_out), .debug_event_pin_i(pin_w),
        .debug_event_pin_o(dbg_o), .debug_event_pin_oe_o(dbg_oe),
        .instr_done_i(instr_done), .breakpoint_i(brk), .save_pipe_o(save),
        .debug_mode_o(dbg_mode), .cmd_data_o(cmd_data), .cmd_valid_o(cmd_valid));
    // ====================
    // Observers
    always @(posedge clk_i) begin
        oe_cnt <= oe_cnt + int'(dbg_oe);
        save_cnt <= save_cnt + int'(save);
        if (cmd_valid === 1'b1) cmd_q.push_back(cmd_data);
    end
    always @(ser_out.tdo) if (tck === 1'b1) check("tdo_edge", 1, 0);
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic enter(input bit by_pin);
        int oe0;
        int sv0;
        oe0 = oe_cnt;
        sv0 = save_cnt;
        @(posedge clk_i);
        if (by_pin) begin
            ctl_u.pull(1'b1);
            repeat ($urandom_range(8, 4)) @(negedge clk_i);
            check("early_entry", {save, dbg_mode}, 0);
            @(posedge clk_i);
            instr_done <= 1'b1;
        end else begin
            brk <= 1'b1;
            @(posedge clk_i);
            brk <= 1'b0;
        end
        for (int i = 0; i < 8 && dbg_mode !== 1'b1; i++) @(negedge clk_i);
        ctl_u.pull(1'b0);
        @(posedge clk_i);
        instr_done <= 1'b0;
        repeat (10) @(negedge clk_i);
        check("debug_mode", dbg_mode, 1);
        check("ack_cycles", oe_cnt - oe0, 3);
        check("save_pulse", save_cnt - sv0, 1);
        check("pin_released", pin_w, 1);
    endtask
    // ====================
    // Main sequence
    initial begin
        logic b;
        void'($urandom(32'h888d));
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        ctl_u.treset();
        ctl_u.step(1'b0, 1'b0, b);
        check("oe_idle", ser_out.tdo_oe, 0);
        ctl_u.shift(1, 4, `JDP_IR_IDCODE, q);
        check("ir_capture", q, `JDP_IR_CAPTURE);
        ctl_u.shift(0, 32, 0, q);
        check("idcode", q, `JDP_ID_VALUE);
        ctl_u.shift(1, 4, `JDP_IR_BYPASS, q);
        v = $urandom;
        ctl_u.shift(0, 32, v, q);
        check("bypass", q, {v[30:0], 1'b0});
        ctl_u.step(1'b1, 1'b0, b);
        ctl_u.step(1'b0, 1'b0, b);
        ctl_u.step(1'b0, 1'b0, b);
        #1;
        check("oe_shift", ser_out.tdo_oe, 1);
        ctl_u.treset();
        check("oe_test_reset", ser_out.tdo_oe, 0);
        ctl_u.step(1'b0, 1'b0, b);
        enter(1);
        ctl_u.shift(1, 4, `JDP_IR_DEBUG, q);
        v = $urandom;
        ctl_u.shift(0, 32, v, q);
        for (int i = 0; i < 10 && cmd_q.size() == 0; i++) @(negedge clk_i);
        check("cmd_count", cmd_q.size(), 1);
        if (cmd_q.size() > 0) check("cmd_data", cmd_q.pop_front(), v);
        q = oe_cnt;
        ctl_u.pull(1'b1);
        repeat (8) @(negedge clk_i);
        check("no_reentry", oe_cnt - q, 0);
        ctl_u.pull(1'b0);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(negedge clk_i);
        check("mode_cleared", dbg_mode, 0);
        enter(0);
        complete_run();
    end
    initial begin
        #400000;
        n_mismatch++;
        complete_run();
    end
endmodule
